// [lpmc_top.sv]
`timescale 1ns/10ps
// Behaviour
// [RULE_01] stop instruction enters stop if option enabled, else forces chip reset
// [RULE_02] stop mode turns oscillator off, halting everything including watchdog
// [RULE_03] stop entry drops pending timer interrupt and disables timer interrupts
// [RULE_04] stop entry clears the timer prescaler
// [RULE_05] stop entry clears interrupt mask bit and sets external irq enable
// [RULE_06] stop leaves other registers, memory and io lines untouched
// [RULE_07] stop exits only on irq pin, reset, port a/c fall, serial rise
// [RULE_08] stop exit holds clocks off for 4064 processor clock cycles
// [RULE_09] wait halts processor clock and internal bus activity
// [RULE_10] wait keeps timer clocks running for timer interrupts and watchdog
// [RULE_11] wait instruction clears the interrupt mask bit
// [RULE_12] wait preserves other registers, memory and io line states
// [RULE_13] wait exits on timer irq, irq pin, reset, port a/c fall, serial rise
// [RULE_14] software avoids stop and wait while watchdog is enabled
// [RULE_15] after stabilization restart processor clock and hand over to wake sequence
module lpmc_top
  import lpmc_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic stop_instr,
  input wire logic wait_instr,
  input wire logic stop_option_enable,
  input wire logic ext_reset,
  input wire logic irq_pin_request,
  input wire logic [PORT_W-1:0] port_a_pins,
  input wire logic [PORT_W-1:0] port_c_pins,
  input wire logic [PORT_W-1:0] port_a_wake_enable,
  input wire logic [PORT_W-1:0] port_c_wake_enable,
  input wire logic serial_link_wake_pin,
  input wire logic timer_irq_a,
  input wire logic timer_irq_b,
  output logic osc_enable,
  output logic cpu_clock_enable,
  output logic timer_clock_enable,
  output logic watchdog_clock_enable,
  output logic timer_irq_clear,
  output logic timer_irq_disable,
  output logic prescaler_clear,
  output logic ccr_i_clear,
  output logic external_irq_enable_set,
  output logic chip_reset,
  output logic wake_resume,
  output logic stop_active,
  output logic wait_active
);
  lpmc_state_t state;
  lpmc_state_t next_state;
  logic [PORT_W-1:0] prev_a;
  logic [PORT_W-1:0] prev_c;
  logic prev_serial;
  logic [RST_CNT_W-1:0] rst_cnt;
  logic [RST_CNT_W-1:0] next_rst_cnt;
  logic next_timer_irq_clear;
  logic next_timer_irq_disable;
  logic next_prescaler_clear;
  logic next_ccr_i_clear;
  logic next_external_irq_enable_set;
  logic next_wake_resume;
  logic stab_start;
  logic stab_done;
  logic port_fall;
  logic serial_rise;
  logic stop_wake;
  logic wait_wake;

  // ****************************************************************
  // wake source detection
  // ****************************************************************
  function automatic logic any_fall(input logic [PORT_W-1:0] prev, input logic [PORT_W-1:0] now,
                                    input logic [PORT_W-1:0] en);
    any_fall = |(prev & ~now & en);
  endfunction

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      prev_a <= PORT_IDLE;
      prev_c <= PORT_IDLE;
      prev_serial <= 1'b0;
    end
    else
    begin
      prev_a <= port_a_pins;
      prev_c <= port_c_pins;
      prev_serial <= serial_link_wake_pin;
    end
  end

  assign port_fall = any_fall(prev_a, port_a_pins, port_a_wake_enable)
                   | any_fall(prev_c, port_c_pins, port_c_wake_enable);
  assign serial_rise = serial_link_wake_pin & ~prev_serial;
  assign stop_wake = irq_pin_request | ext_reset | port_fall | serial_rise; // RULE_07
  assign wait_wake = stop_wake | timer_irq_a | timer_irq_b; // RULE_13

  // ****************************************************************
  // mode state machine
  // ****************************************************************
  always_comb
  begin
    next_state = state;
    next_rst_cnt = rst_cnt;
    next_timer_irq_clear = 1'b0; // RULE_06 RULE_12
    next_timer_irq_disable = 1'b0;
    next_prescaler_clear = 1'b0;
    next_ccr_i_clear = 1'b0;
    next_external_irq_enable_set = 1'b0;
    next_wake_resume = 1'b0;
    stab_start = 1'b0;
    case (state)
      LPMC_RUN:
      begin
        if (stop_instr)
        begin
          if (stop_option_enable) // RULE_01
          begin
            next_state = LPMC_STOP;
            next_timer_irq_clear = 1'b1; // RULE_03
            next_timer_irq_disable = 1'b1; // RULE_03
            next_prescaler_clear = 1'b1; // RULE_04
            next_ccr_i_clear = 1'b1; // RULE_05
            next_external_irq_enable_set = 1'b1; // RULE_05
          end
          else
          begin
            next_state = LPMC_CHIPRST; // RULE_01
            next_rst_cnt = RST_CNT_RESET;
          end
        end
        else if (wait_instr)
        begin
          next_state = LPMC_WAIT;
          next_ccr_i_clear = 1'b1; // RULE_11
        end
      end
      LPMC_STOP:
      begin
        if (stop_wake) // RULE_07
        begin
          next_state = LPMC_STAB;
          stab_start = 1'b1;
        end
      end
      LPMC_STAB:
      begin
        if (stab_done) // RULE_08
        begin
          next_state = LPMC_RUN;
          next_wake_resume = 1'b1; // RULE_15
        end
      end
      LPMC_WAIT:
      begin
        if (wait_wake) // RULE_13
        begin
          next_state = LPMC_RUN;
          next_wake_resume = 1'b1;
        end
      end
      LPMC_CHIPRST:
      begin
        if (rst_cnt == RST_CNT_LAST)
        begin
          next_state = LPMC_RUN;
        end
        else
        begin
          next_rst_cnt = rst_cnt + 3'h1;
        end
      end
      default:
      begin
        next_state = LPMC_RUN;
      end
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state <= LPMC_RUN;
      rst_cnt <= RST_CNT_RESET;
      timer_irq_clear <= 1'b0;
      timer_irq_disable <= 1'b0;
      prescaler_clear <= 1'b0;
      ccr_i_clear <= 1'b0;
      external_irq_enable_set <= 1'b0;
      wake_resume <= 1'b0;
    end
    else
    begin
      state <= next_state;
      rst_cnt <= next_rst_cnt;
      timer_irq_clear <= next_timer_irq_clear;
      timer_irq_disable <= next_timer_irq_disable;
      prescaler_clear <= next_prescaler_clear;
      ccr_i_clear <= next_ccr_i_clear;
      external_irq_enable_set <= next_external_irq_enable_set;
      wake_resume <= next_wake_resume;
    end
  end

  // counts in the stabilization state only; no register or io state is touched here
  lpmc_stab_counter u_stab
  (
    .clock(clock),
    .rst(rst),
    .start(stab_start),
    .run(state == LPMC_STAB),
    .done(stab_done)
  );

  // ****************************************************************
  // clock gating, status and chip reset outputs
  // ****************************************************************
  assign stop_active = (state == LPMC_STOP) || (state == LPMC_STAB);
  assign wait_active = (state == LPMC_WAIT);
  assign osc_enable = (state != LPMC_STOP); // RULE_02
  assign cpu_clock_enable = (state == LPMC_RUN); // RULE_09 RULE_08
  assign timer_clock_enable = (state == LPMC_RUN) || (state == LPMC_WAIT); // RULE_10
  assign watchdog_clock_enable = (state == LPMC_RUN) || (state == LPMC_WAIT); // RULE_02 RULE_10
  assign chip_reset = (state == LPMC_CHIPRST); // RULE_01
endmodule

// [lpmc_pkg.sv]
package lpmc_pkg;
  // oscillator stabilization delay in internal processor clock cycles
  localparam int unsigned STAB_DELAY_CYCLES = 4064;
  localparam int unsigned CNT_W = 12;
  localparam logic [CNT_W-1:0] CNT_RESET = 12'h000;
  localparam logic [CNT_W-1:0] CNT_LAST = 12'(STAB_DELAY_CYCLES - 1);
  // width of port a and port c wake inputs
  localparam int unsigned PORT_W = 8;
  localparam logic [PORT_W-1:0] PORT_IDLE = 8'hFF;
  // length of the reset pulse produced by a stop with stop option disabled
  localparam int unsigned RST_PULSE_CYCLES = 4;
  localparam int unsigned RST_CNT_W = 3;
  localparam logic [RST_CNT_W-1:0] RST_CNT_LAST = 3'(RST_PULSE_CYCLES - 1);
  localparam logic [RST_CNT_W-1:0] RST_CNT_RESET = 3'h0;

  typedef enum logic [2:0]
  {
    LPMC_RUN,
    LPMC_STOP,
    LPMC_WAIT,
    LPMC_STAB,
    LPMC_CHIPRST
  } lpmc_state_t;
endpackage

// [lpmc_stab_counter.sv]
`timescale 1ns/10ps
module lpmc_stab_counter
  import lpmc_pkg::*;
#(
  parameter logic [CNT_W-1:0] LAST = CNT_LAST
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic start,
  input wire logic run,
  output logic done
);
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic next_done;

  always_comb
  begin
    next_count = count;
    next_done = 1'b0;
    if (start)
    begin
      next_count = CNT_RESET;
    end
    else if (run)
    begin
      if (count == LAST)
      begin
        next_done = 1'b1;
        next_count = CNT_RESET;
      end
      else
      begin
        next_count = count + 12'h001;
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      count <= CNT_RESET;
      done <= 1'b0;
    end
    else
    begin
      count <= next_count;
      done <= next_done;
    end
  end
endmodule

// [lpmc_cpu_model.sv]
`timescale 1ns/10ps
module lpmc_cpu_model
(
  input wire logic clock,
  input wire logic rst,
  input wire logic cpu_clock_enable,
  input wire logic go_stop,
  input wire logic go_wait,
  output logic stop_instr,
  output logic wait_instr
);
  // instructions only while the cpu clock runs; watchdog never enabled
  always_ff @(posedge clock)
  begin
    stop_instr <= !rst && go_stop && cpu_clock_enable;
    wait_instr <= !rst && go_wait && cpu_clock_enable;
  end
endmodule

// [lpmc_top_props.sv]
`timescale 1ns/10ps
module lpmc_top_props
(
  input wire logic clock,
  input wire logic rst,
  input wire logic stop_instr,
  input wire logic wait_instr,
  input wire logic stop_option_enable,
  input wire logic irq_pin_request,
  input wire logic timer_irq_a,
  input wire logic timer_irq_b,
  input wire logic osc_enable,
  input wire logic cpu_clock_enable,
  input wire logic timer_clock_enable,
  input wire logic watchdog_clock_enable,
  input wire logic timer_irq_clear,
  input wire logic prescaler_clear,
  input wire logic ccr_i_clear,
  input wire logic external_irq_enable_set,
  input wire logic chip_reset,
  input wire logic wake_resume,
  input wire logic stop_active,
  input wire logic wait_active
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic [12:0] stab_cnt;
  always_ff @(posedge clock)
    stab_cnt <= (rst || !(stop_active && osc_enable)) ? 13'h0000 : stab_cnt + 13'h0001;
  sequence s_stop_in;
    !osc_enable && ccr_i_clear && prescaler_clear && timer_irq_clear && external_irq_enable_set;
  endsequence
  sequence s_held;
    (stop_active && $past(stop_active)) || (wait_active && $past(wait_active));
  endsequence
  sequence s_rst_pulse;
    chip_reset [*4] ##1 !chip_reset;
  endsequence
  stop_entry_a: assert property (stop_instr && cpu_clock_enable && stop_option_enable |=> s_stop_in)
    else $error("stop entry");
  chip_rst_a: assert property (stop_instr && cpu_clock_enable && !stop_option_enable |=> s_rst_pulse)
    else $error("chip reset");
  wait_entry_a: assert property (wait_instr && !stop_instr && cpu_clock_enable |=> wait_active && ccr_i_clear)
    else $error("wait entry");
  stop_clk_a: assert property (!osc_enable |-> !watchdog_clock_enable && !timer_clock_enable)
    else $error("stop clocks");
  wait_clk_a: assert property (wait_active |-> timer_clock_enable && !cpu_clock_enable)
    else $error("wait clocks");
  stop_wake_a: assert property (!osc_enable && irq_pin_request |=> osc_enable)
    else $error("stop wake");
  wait_exit_a: assert property (wait_active && (timer_irq_a || timer_irq_b) |=> !wait_active && wake_resume)
    else $error("wait exit");
  stab_len_a: assert property ($fell(stop_active) |-> stab_cnt >= 13'h0FDF && stab_cnt <= 13'h0FE3)
    else $error("stab length");
  resume_a: assert property ($fell(stop_active) |-> ##[0:1] wake_resume)
    else $error("resume");
  hold_quiet_a: assert property (s_held |-> !(ccr_i_clear || prescaler_clear || timer_irq_clear))
    else $error("quiet hold");
endmodule
bind lpmc_top lpmc_top_props lpmc_top_props_i (.clock(clock), .rst(rst), .stop_instr(stop_instr),
  .wait_instr(wait_instr), .stop_option_enable(stop_option_enable), .irq_pin_request(irq_pin_request),
  .timer_irq_a(timer_irq_a), .timer_irq_b(timer_irq_b), .osc_enable(osc_enable),
  .cpu_clock_enable(cpu_clock_enable), .timer_clock_enable(timer_clock_enable),
  .watchdog_clock_enable(watchdog_clock_enable), .timer_irq_clear(timer_irq_clear),
  .prescaler_clear(prescaler_clear), .ccr_i_clear(ccr_i_clear),
  .external_irq_enable_set(external_irq_enable_set), .chip_reset(chip_reset),
  .wake_resume(wake_resume), .stop_active(stop_active), .wait_active(wait_active));

// [tb.sv]
`timescale 1ns/10ps
module tb;
  import lpmc_pkg::*;
  logic clock = 0, rst = 1, opt = 1, ext = 0, irq = 0, ser = 0, tma = 0, tmb = 0;
  logic go_stop = 0, go_wait = 0, si, wi;
  logic [PORT_W-1:0] pa = 8'hFF, pc = 8'hFF, ea = 8'hFF, ec = 8'hFF;
  logic osc, cpu, tmr, wdg, tic, tid, psc, cci, eis, crst, wr, sa, wa;
  int bad_count = 0, samples_checked = 0;
  always #5 clock = ~clock;
  lpmc_cpu_model lpmc_cpu_model_i (.clock(clock), .rst(rst), .cpu_clock_enable(cpu), .go_stop(go_stop),
    .go_wait(go_wait), .stop_instr(si), .wait_instr(wi));
  lpmc_top lpmc_top_i (.clock(clock), .rst(rst), .stop_instr(si), .wait_instr(wi), .stop_option_enable(opt),
    .ext_reset(ext), .irq_pin_request(irq), .port_a_pins(pa), .port_c_pins(pc), .port_a_wake_enable(ea),
    .port_c_wake_enable(ec), .serial_link_wake_pin(ser), .timer_irq_a(tma), .timer_irq_b(tmb),
    .osc_enable(osc), .cpu_clock_enable(cpu), .timer_clock_enable(tmr), .watchdog_clock_enable(wdg),
    .timer_irq_clear(tic), .timer_irq_disable(tid), .prescaler_clear(psc), .ccr_i_clear(cci),
    .external_irq_enable_set(eis), .chip_reset(crst), .wake_resume(wr), .stop_active(sa), .wait_active(wa));
  task close_out;
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e)
    begin
      bad_count++;
      $display("Error t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task tick;
    @(posedge clock);
    #1;
  endtask
  task src(input int s, input logic v);
    case (s)
      0: tma = v;
      1: tmb = v;
      2: irq = v;
      3: ext = v;
      4: pa[3] = !v;
      5: pc[6] = !v;
      default: ser = v;
    endcase
  endtask
  // enter stop or wait, wake by source s, time the way back
  task t_mode(input logic stp, input int s);
    int n;
    go_stop = stp;
    go_wait = !stp;
    tick;
    go_stop = 0;
    go_wait = 0;
    n = 0;
    while (sa !== 1'b1 && wa !== 1'b1 && n < 5)
    begin
      tick;
      n++;
    end
    chk({sa, wa, osc, cpu, cci, psc & tic & tid & eis}, {stp, !stp, !stp, 1'b0, 1'b1, stp});
    chk({tmr, wdg}, {2{!stp}});
    tick;
    chk({cci, psc, tic, tid, eis}, 8'h00);
    if (stp)
    begin
      // timer irq and a fall on a disabled port bit must not wake stop
      tma = 1;
      ea = 8'hF7;
      pa[3] = 0;
      tick;
      tick;
      tma = 0;
      pa[3] = 1;
      tick;
      ea = 8'hFF;
      chk(osc, 0);
    end
    src(s, 1);
    tick;
    src(s, 0);
    n = 0;
    while (wr !== 1'b1 && n < 4100)
    begin
      tick;
      n++;
    end
    chk(cpu, 1);
    if (stp) chk(n >= 4063 && n <= 4067, 1);
    else chk(n <= 2, 1);
    tick;
    $display("mode %0d source %0d done", stp, s);
  endtask
  task t_chiprst;
    opt = 0;
    go_stop = 1;
    tick;
    go_stop = 0;
    tick;
    repeat (4)
    begin
      chk(crst, 1);
      tick;
    end
    chk({crst, sa}, 0);
    opt = 1;
    tick;
    $display("chip reset done");
  endtask
  initial
  begin
    repeat (12) @(posedge clock);
    #1;
    rst = 0;
    tick;
    for (int s = 0; s < 7; s++) t_mode(0, s);
    for (int s = 2; s < 7; s++) t_mode(1, s);
    t_chiprst;
    close_out;
  end
  initial
  begin
    #1000000;
    bad_count++;
    close_out;
  end
endmodule
